// ===== hdl/irp_ingress_rate_policer.sv
// ingress metering, coloring, broadcast storm limiting and flood buffer cap
// assumes one packet summary pulse per received packet from the port receive paths
`timescale 1ns/1ps
module irp_ingress_rate_policer
  import irp_pkg::*;
#(
  parameter int LEN_W = 11,
  parameter int BUF_W = 8,
  parameter int THROT_PERIOD = THROT_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pkt_valid,
  input wire logic [1:0] pkt_port,
  input wire logic [LEN_W-1:0] pkt_len,
  input wire logic pkt_bcast,
  input wire logic pkt_flood,
  input wire logic alr_static_hit,
  input wire logic [2:0] alr_static_prio,
  input wire logic pkt_ipv4,
  input wire logic pkt_ipv6,
  input wire logic [7:0] pkt_tos,
  input wire logic pkt_vlan_tagged,
  input wire logic [2:0] pkt_vlan_prio,
  input wire logic [2:0] ingress_rate_config_reg,
  input wire logic rate_cmd_strobe,
  input wire logic [6:0] ingress_rate_command_reg,
  input wire logic [15:0] ingress_rate_write_data_reg,
  input wire logic [7:0] yellow_drop_level,
  input wire logic [4:0] prio_source_ctrl,
  input wire logic map_wr_en,
  input wire logic [5:0] map_wr_addr,
  input wire logic [2:0] map_wr_data,
  input wire logic [71:0] vlan_regen_table,
  input wire logic [8:0] port_default_prio,
  input wire logic [8:0] port_bcast_prio,
  input wire logic [26:0] broadcast_throttle_reg,
  input wire logic [BUF_W-1:0] broadcast_buffer_level_reg,
  input wire logic flood_buf_take,
  input wire logic flood_buf_release,
  output logic result_valid,
  output irp_color_t result_color,
  output logic result_drop,
  output logic [4:0] result_stream,
  output logic [2:0] result_prio,
  output logic [BUF_W-1:0] flood_buf_count
);
  localparam int PER_W = 22;
  localparam int THR_W = $clog2(THROT_PERIOD + 1);

  wire rate_en = ingress_rate_config_reg[0];
  wire [1:0] rate_mode = ingress_rate_config_reg[2:1];
  wire [1:0] cmd_op = ingress_rate_command_reg[6:5];
  wire [4:0] cmd_stream = ingress_rate_command_reg[4:0];
  wire [15:0] len16 = 16'(pkt_len);

  // flow priority; the map table is left uninitialised, host fills it
  logic [2:0] map_a [64];
  always_ff @(posedge clock) begin
    if (map_wr_en) begin
      map_a[map_wr_addr] <= map_wr_data;
    end
  end

  wire use_map = prio_source_ctrl[3];
  wire [2:0] ip_prio = use_map ? map_a[pkt_tos[7:2]] : pkt_tos[7:5];
  wire ip_ok = prio_source_ctrl[2] && (pkt_ipv4 || (pkt_ipv6 && use_map));
  wire vlan_ok = prio_source_ctrl[1] && pkt_vlan_tagged;
  wire [2:0] vlan_prio = vlan_regen_table[int'({pkt_port, pkt_vlan_prio}) * 3 +: 3];
  wire [2:0] dflt_prio = pkt_bcast ? port_bcast_prio[int'(pkt_port) * 3 +: 3]
                                   : port_default_prio[int'(pkt_port) * 3 +: 3];
  wire vlan_first = prio_source_ctrl[4];
  // lookup entry first, then tag or ip in chosen order, then port default
  wire [2:0] flow_prio = (prio_source_ctrl[0] && alr_static_hit) ? alr_static_prio :
                         (vlan_ok && (vlan_first || !ip_ok)) ? vlan_prio :
                         ip_ok ? ip_prio : dflt_prio;

  wire [4:0] stream_sel = (rate_mode == IRP_MODE_PORT) ? {3'h0, pkt_port} :
                          (rate_mode == IRP_MODE_PRIO) ? {2'h0, flow_prio} :
                          {pkt_port, flow_prio};

  // shared burst caps
  logic [15:0] cbs;
  logic [15:0] ebs;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cbs <= BUCKET_INIT;
      ebs <= BUCKET_INIT;
    end else if (rate_cmd_strobe) begin
      if (cmd_op == IRP_OP_CBS) begin
        cbs <= ingress_rate_write_data_reg;
      end
      if (cmd_op == IRP_OP_EBS) begin
        ebs <= ingress_rate_write_data_reg;
      end
    end
  end

  logic [15:0] commit_q [NUM_STREAMS];
  logic [15:0] excess_q [NUM_STREAMS];
  wire meter_go = pkt_valid && rate_en;
  wire [15:0] commit_sel = commit_q[stream_sel];
  wire [15:0] excess_sel = excess_q[stream_sel];
  wire fits_commit = commit_sel >= len16;
  wire fits_excess = excess_sel >= len16;

  for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_stream
    logic [15:0] cir;
    logic [15:0] commit;
    logic [15:0] excess;
    logic [PER_W-1:0] acc;
    // settings below the minimum all run at the fastest byte time
    wire [15:0] cir_eff = (cir < CIR_MIN_SETTING) ? CIR_MIN_SETTING : cir;
    // byte time in ns, tracked exactly against 8 ns clock steps
    wire [PER_W-1:0] period = PER_W'((17'(cir_eff) + 17'h0_0001) * CIR_STEP_NS);
    wire [PER_W-1:0] acc_step = acc + PER_W'(CLK_PERIOD_NS);
    wire tick = acc_step >= period;
    wire hit = meter_go && (stream_sel == 5'(s));
    wire credit_c = tick && (commit < cbs);
    wire credit_e = tick && (commit >= cbs) && (excess < ebs);
    wire [15:0] debit_c = (hit && fits_commit) ? len16 : 16'h0000;
    wire [15:0] debit_e = (hit && !fits_commit && fits_excess) ? len16 : 16'h0000;
    wire cir_wr = rate_cmd_strobe && (cmd_op == IRP_OP_CIR) && (cmd_stream == 5'(s));
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        cir <= CIR_INIT;
        acc <= '0;
        commit <= BUCKET_INIT;
        excess <= BUCKET_INIT;
      end else begin
        if (cir_wr) begin
          cir <= ingress_rate_write_data_reg;
        end
        acc <= tick ? acc_step - period : acc_step;
        commit <= commit + 16'(credit_c) - debit_c;
        excess <= excess + 16'(credit_e) - debit_e;
      end
    end
    assign commit_q[s] = commit;
    assign excess_q[s] = excess;
  end

  // broadcast storm limiting
  logic [THR_W-1:0] thr_timer;
  wire thr_tick = (thr_timer == '0);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      thr_timer <= THR_W'(THROT_PERIOD - 1);
    end else begin
      thr_timer <= thr_tick ? THR_W'(THROT_PERIOD - 1) : thr_timer - 1'b1;
    end
  end

  wire [8:0] thr_cfg = broadcast_throttle_reg[int'(pkt_port) * 9 +: 9];
  wire [16:0] storm_allow = 17'(thr_cfg[7:0]) * 17'(BCAST_UNIT_BYTES);
  logic [16:0] bcnt_q [NUM_PORTS];
  wire [16:0] storm_sum = bcnt_q[pkt_port] + 17'(pkt_len);
  wire storm_drop = pkt_bcast && thr_cfg[8] && (storm_sum > storm_allow);

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [16:0] bcnt;
    wire add = pkt_valid && pkt_bcast && !storm_drop && (pkt_port == 2'(p));
    wire [16:0] add_len = add ? 17'(pkt_len) : 17'h0_0000;
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        bcnt <= '0;
      end else begin
        bcnt <= thr_tick ? add_len : bcnt + add_len;
      end
    end
    assign bcnt_q[p] = bcnt;
  end

  // flooded traffic buffer cap
  wire cap_drop = pkt_flood && (flood_buf_count >= broadcast_buffer_level_reg);
  wire buf_up = flood_buf_take && !flood_buf_release && (flood_buf_count != '1);
  wire buf_dn = !flood_buf_take && flood_buf_release && (flood_buf_count != '0);
  wire [BUF_W-1:0] next_buf_count = buf_up ? flood_buf_count + 1'b1 :
                                    buf_dn ? flood_buf_count - 1'b1 : flood_buf_count;

  // yellow discard draw
  logic [15:0] lfsr;
  wire yellow_lose = lfsr[7:0] < yellow_drop_level;

  wire irp_color_t next_color = !rate_en ? IRP_GREEN :
                                fits_commit ? IRP_GREEN :
                                fits_excess ? IRP_YELLOW : IRP_RED;
  wire next_drop = storm_drop || cap_drop || (next_color == IRP_RED) ||
                   ((next_color == IRP_YELLOW) && yellow_lose);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lfsr <= LFSR_SEED;
      flood_buf_count <= '0;
      result_valid <= 1'b0;
      result_color <= IRP_GREEN;
      result_drop <= 1'b0;
      result_stream <= '0;
      result_prio <= '0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      flood_buf_count <= next_buf_count;
      result_valid <= pkt_valid;
      if (pkt_valid) begin
        result_color <= next_color;
        result_drop <= next_drop;
        result_stream <= stream_sel;
        result_prio <= flow_prio;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_meter_off_green:
    assert property (pkt_valid && !rate_en |=> result_valid && result_color == IRP_GREEN)
      else $error("metering acted while disabled");
  chk_green_fit:
    assert property (meter_go && fits_commit |=> result_color == IRP_GREEN)
      else $error("fitting packet not green");
  chk_yellow_fit:
    assert property (meter_go && !fits_commit && fits_excess |=> result_color == IRP_YELLOW)
      else $error("excess fit not yellow");
  chk_red_dropped:
    assert property (meter_go && !fits_commit && !fits_excess
                     |=> result_color == IRP_RED && result_drop)
      else $error("red packet not dropped");
  chk_port_stream:
    assert property (pkt_valid && rate_mode == IRP_MODE_PORT
                     |=> result_stream[1:0] == $past(pkt_port) && result_stream[4:2] == 3'h0)
      else $error("port stream index wrong");
  chk_bucket_init:
    assert property ($rose(reset_n) |-> commit_q[0] == BUCKET_INIT && excess_q[23] == BUCKET_INIT)
      else $error("bucket not initialised");
  chk_storm_drop:
    assert property (pkt_valid && storm_drop |=> result_valid && result_drop)
      else $error("storm excess not dropped");
  chk_buffer_cap:
    assert property (pkt_valid && cap_drop |=> result_drop)
      else $error("flood over cap not dropped");
  chk_interval_clear:
    assert property (thr_tick && !pkt_valid |=> bcnt_q[0] == 17'h0_0000)
      else $error("broadcast count not cleared");

  cov_yellow: cover property (meter_go && !fits_commit && fits_excess);
  cov_red: cover property (meter_go && !fits_commit && !fits_excess);
  cov_storm: cover property (pkt_valid && storm_drop);
  cov_cap: cover property (pkt_valid && cap_drop);
endmodule

// ===== include/irp_pkg.sv
// constants and types of the ingress rate policer
// assumes one core clock and plain configuration ports, no register bus
package irp_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CIR_STEP_NS = 20;
  localparam logic [15:0] CIR_MIN_SETTING = 16'h0003;
  localparam logic [15:0] CIR_INIT = 16'h0000;
  localparam logic [15:0] BUCKET_INIT = 16'h0600;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam int NUM_PORTS = 3;
  localparam int NUM_STREAMS = 24;
  localparam int BCAST_UNIT_BYTES = 64;
  localparam int THROT_INTERVAL_NS = 1720000;
  localparam int THROT_CYCLES = THROT_INTERVAL_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    IRP_GREEN = 2'b00,
    IRP_YELLOW = 2'b01,
    IRP_RED = 2'b10
  } irp_color_t;
  typedef enum logic [1:0] {
    IRP_MODE_PORT = 2'b00,
    IRP_MODE_PRIO = 2'b01,
    IRP_MODE_BOTH = 2'b10
  } irp_mode_t;
  typedef enum logic [1:0] {
    IRP_OP_CIR = 2'b00,
    IRP_OP_CBS = 2'b01,
    IRP_OP_EBS = 2'b10
  } irp_op_t;
endpackage

// ===== testbench/irp_far_side.sv
// far side of the policer: port receive paths and the host command writer
// assumes the bench calls one task at a time and makes the clock
`timescale 1ns/1ps
module irp_far_side (
  input wire logic clock,
  output logic pkt_valid,
  output logic [1:0] pkt_port,
  output logic [10:0] pkt_len,
  output logic pkt_bcast,
  output logic pkt_flood,
  output logic rate_cmd_strobe,
  output logic [6:0] ingress_rate_command_reg,
  output logic [15:0] ingress_rate_write_data_reg
);
  initial begin
    {pkt_valid, pkt_bcast, pkt_flood, rate_cmd_strobe} = 4'h0;
    {pkt_port, pkt_len} = 13'h0000;
    {ingress_rate_command_reg, ingress_rate_write_data_reg} = 23'h00_0000;
  end
  // one summary pulse per packet; fields scrambled once the pulse is gone
  task automatic send(input logic [1:0] p, input logic [10:0] n, input logic b, input logic f);
    @(posedge clock);
    pkt_valid <= 1'b1;
    {pkt_port, pkt_len, pkt_bcast, pkt_flood} <= {p, n, b, f};
    @(posedge clock);
    pkt_valid <= 1'b0;
    {pkt_port, pkt_len, pkt_bcast, pkt_flood} <= ~{p, n, b, f};
  endtask
  // write data goes out with the command under one strobe
  task automatic cmd(input logic [1:0] op, input logic [4:0] s, input logic [15:0] d);
    @(posedge clock);
    {ingress_rate_command_reg, ingress_rate_write_data_reg} <= {op, s, d};
    rate_cmd_strobe <= 1'b1;
    @(posedge clock);
    rate_cmd_strobe <= 1'b0;
    {ingress_rate_command_reg, ingress_rate_write_data_reg} <= ~{op, s, d};
  endtask
endmodule

// ===== testbench/irp_ingress_rate_policer_bench.sv
// self-checking bench of the ingress rate policer
// assumes the design package and a throttle interval shortened to 200 cycles
`timescale 1ns/1ps
module irp_ingress_rate_policer_bench;
  import irp_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic pkt_valid, pkt_bcast, pkt_flood, rate_cmd_strobe, result_valid, result_drop;
  logic [1:0] pkt_port;
  logic [10:0] pkt_len;
  logic [6:0] ingress_rate_command_reg;
  logic [15:0] ingress_rate_write_data_reg;
  logic alr_static_hit = 1'b0, pkt_ipv4 = 1'b0, pkt_vlan_tagged = 1'b0, map_wr_en = 1'b0;
  logic flood_buf_take = 1'b0, flood_buf_release = 1'b0, pkt_ipv6 = 1'b0;
  logic [2:0] result_prio;
  logic [2:0] alr_static_prio = 3'h0, pkt_vlan_prio = 3'h0, ingress_rate_config_reg = 3'h0;
  logic [2:0] map_wr_data = 3'h0;
  logic [5:0] map_wr_addr = 6'h00;
  logic [7:0] pkt_tos = 8'h00, broadcast_buffer_level_reg = 8'hff, flood_buf_count;
  logic [4:0] prio_source_ctrl = 5'h00, result_stream;
  logic [26:0] broadcast_throttle_reg = 27'h000_0000;
  irp_color_t result_color;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int up_cycles = 0;
  always #4 clock = ~clock;
  irp_far_side far_u (.clock, .pkt_valid, .pkt_port, .pkt_len, .pkt_bcast, .pkt_flood,
    .rate_cmd_strobe, .ingress_rate_command_reg, .ingress_rate_write_data_reg);
  irp_ingress_rate_policer #(.THROT_PERIOD(200)) dut_u (.clock, .reset_n, .pkt_valid,
    .pkt_port, .pkt_len, .pkt_bcast, .pkt_flood, .alr_static_hit, .alr_static_prio,
    .pkt_ipv4, .pkt_ipv6, .pkt_tos, .pkt_vlan_tagged, .pkt_vlan_prio,
    .ingress_rate_config_reg, .rate_cmd_strobe, .ingress_rate_command_reg,
    .ingress_rate_write_data_reg, .yellow_drop_level(8'h00), .prio_source_ctrl, .map_wr_en,
    .map_wr_addr, .map_wr_data, .vlan_regen_table(72'h00_0000_0001_0000_0000),
    .port_default_prio(9'h0a9), .port_bcast_prio(9'h1b6), .broadcast_throttle_reg,
    .broadcast_buffer_level_reg, .flood_buf_take, .flood_buf_release, .result_valid,
    .result_color, .result_drop, .result_stream, .result_prio, .flood_buf_count);
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one packet, then its registered result half a cycle after it was taken
  task automatic pkt(input logic [1:0] p, input logic [10:0] n, input logic b, input logic f,
                     input logic [1:0] c, input logic d, input logic [4:0] s);
    far_u.send(p, n, b, f);
    @(negedge clock);
    chk("valid", 16'h0001, {15'h0000, result_valid});
    chk("color", {14'h0000, c}, {14'h0000, result_color});
    chk("drop", {15'h0000, d}, {15'h0000, result_drop});
    chk("stream", {11'h000, s}, {11'h000, result_stream});
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    up_cycles <= reset_n ? up_cycles + 1 : 0;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("reset count", 16'h0000, {8'h00, flood_buf_count});
    pkt(2'h0, 11'h7ff, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h00);
    far_u.cmd(2'h0, 5'h00, 16'hffff);
    far_u.cmd(2'h0, 5'h01, 16'h0003);
    @(posedge clock);
    ingress_rate_config_reg <= 3'h1;
    pkt(2'h0, 11'h600, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h00);
    pkt(2'h0, 11'h3e8, 1'b0, 1'b0, IRP_YELLOW, 1'b0, 5'h00);
    pkt(2'h0, 11'h258, 1'b0, 1'b0, IRP_RED, 1'b1, 5'h00);
    pkt(2'h2, 11'h600, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h02);
    pkt(2'h1, 11'h600, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h01);
    pkt(2'h1, 11'h005, 1'b0, 1'b0, IRP_YELLOW, 1'b0, 5'h01);
    repeat (120) @(posedge clock);
    pkt(2'h1, 11'h00a, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h01);
    @(posedge clock);
    ingress_rate_config_reg <= 3'h3;
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h05);
    pkt(2'h1, 11'h040, 1'b1, 1'b0, IRP_GREEN, 1'b0, 5'h06);
    @(posedge clock);
    {prio_source_ctrl, pkt_ipv4, pkt_tos} <= {5'h04, 1'b1, 8'he0};
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h07);
    @(posedge clock);
    {map_wr_en, map_wr_addr, map_wr_data} <= {1'b1, 6'h2d, 3'h3};
    {prio_source_ctrl, pkt_tos} <= {5'h0c, 8'hb4};
    @(posedge clock);
    map_wr_en <= 1'b0;
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h03);
    // ipv6 traffic class octet reaches the map table too
    @(posedge clock);
    {pkt_ipv4, pkt_ipv6} <= 2'b01;
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h03);
    @(posedge clock);
    {prio_source_ctrl, pkt_vlan_tagged, pkt_vlan_prio} <= {5'h02, 1'b1, 3'h2};
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h04);
    // tag and precedence both usable: order bit picks the winner
    @(posedge clock);
    {prio_source_ctrl, pkt_ipv4, pkt_ipv6} <= {5'h06, 1'b1, 1'b0};
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h05);
    @(posedge clock);
    prio_source_ctrl <= 5'h16;
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h04);
    @(posedge clock);
    {prio_source_ctrl, alr_static_hit, alr_static_prio} <= {5'h03, 1'b1, 3'h7};
    pkt(2'h1, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h07);
    chk("prio", 16'h0007, {13'h0000, result_prio});
    @(posedge clock);
    {ingress_rate_config_reg, prio_source_ctrl, alr_static_hit} <= {3'h5, 5'h00, 1'b0};
    pkt(2'h2, 11'h040, 1'b0, 1'b0, IRP_GREEN, 1'b0, 5'h12);
    // storm limiter: 2 x 64 bytes per interval on port 0, port 1 unlimited
    @(posedge clock);
    {ingress_rate_config_reg, broadcast_throttle_reg} <= {3'h0, 27'h000_0102};
    while (up_cycles % 200 != 50) @(posedge clock);
    pkt(2'h0, 11'h040, 1'b1, 1'b0, IRP_GREEN, 1'b0, 5'h00);
    pkt(2'h0, 11'h040, 1'b1, 1'b0, IRP_GREEN, 1'b0, 5'h00);
    pkt(2'h0, 11'h040, 1'b1, 1'b0, IRP_GREEN, 1'b1, 5'h00);
    pkt(2'h1, 11'h7ff, 1'b1, 1'b0, IRP_GREEN, 1'b0, 5'h01);
    repeat (200) @(posedge clock);
    pkt(2'h0, 11'h040, 1'b1, 1'b0, IRP_GREEN, 1'b0, 5'h00);
    @(posedge clock);
    {broadcast_buffer_level_reg, flood_buf_take} <= {8'h02, 1'b1};
    repeat (2) @(posedge clock);
    flood_buf_take <= 1'b0;
    @(negedge clock);
    chk("count", 16'h0002, {8'h00, flood_buf_count});
    pkt(2'h0, 11'h040, 1'b0, 1'b1, IRP_GREEN, 1'b1, 5'h00);
    @(posedge clock);
    flood_buf_release <= 1'b1;
    @(posedge clock);
    flood_buf_release <= 1'b0;
    @(negedge clock);
    chk("count", 16'h0001, {8'h00, flood_buf_count});
    pkt(2'h0, 11'h040, 1'b0, 1'b1, IRP_GREEN, 1'b0, 5'h00);
    give_verdict();
  end
endmodule
